/* File: rtl/pcdfm_top.v */
// What this block does
// RULE1: Reload-rate writes go to holding; applied at period end; reads return holding.
// RULE2: Reload every 1, 2, 4 or 8 periods by rate code.
// RULE3: Independence bit clear gives three complementary pairs, set gives six channels.
// RULE4: Pair polarity bit set inverts both outputs of that pair.
// RULE5: PWM input clock divided by buffered two-bit divider; 00 by 1, 11 by 8.
// RULE6: Divider selection applied at next reload event; reads return holding value.
// RULE7: Rate code 11 means every eighth; divider 01 and 10 divide by 2 and 4.
// RULE8: Deadband counts 8-bit value of undivided PWM input clock cycles.
// RULE9: Deadband value 00h means maximum duration; smallest valid value is 1.
// RULE10: Only first deadband write after reset is taken; reset value 01h.
// RULE11: Both pair outputs held deasserted during deadband.
// RULE12: Pulses shorter than deadband plus filter value, in PWM clocks, are suppressed.
// RULE13: Debug entry raises a fault unless debug mask bit is set.
// RULE14: Fault-1, comparator, fault-0 pin raise faults only when their mask is clear.
// RULE15: Fault mask written once; bits only set by ones, never cleared.
// RULE16: Unmasked fault drives outputs off until recovery conditions are met.
// RULE17: Software writes reserved mask bits zero, programs once before enabling.
// RULE18: Holding values copied to working at reload only when ready bit set.
// RULE19: Masked source never sets its fault status flag.
`timescale 1ns/1ps
`include "pcdfm_map.vh"

module pcdfm_top #(
  parameter PER_W = 12,
  parameter ADDR_W = 26
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire external_count_clock_input,
  input wire fault_zero_pin,
  input wire comparator_in,
  input wire fault_one_in,
  input wire debug_mode,
  output reg [2:0] pwm_high,
  output reg [2:0] pwm_low,
  output reg fault_active,
  output reg irq
);

  // ==================================================
  // Bus access
  wire [23:0] idx = paddr[ADDR_W-1:2];
  wire wr = psel & penable & pready & pwrite;
  wire [7:0] wd = pwdata[7:0];

  // ==================================================
  // Register state
  reg en;
  reg ready;
  reg ext_sel;
  reg [1:0] rl_hold;
  reg [1:0] rl_work;
  reg [1:0] pre_hold;
  reg [1:0] pre_work;
  reg ind;
  reg [2:0] pol;
  reg [7:0] db;
  reg db_lock;
  reg [7:0] mpf;
  reg [7:0] fm;
  reg fm_lock;
  reg [7:0] st;
  reg [7:0] ien;
  reg [PER_W-1:0] per_hold;
  reg [PER_W-1:0] per_work;
  reg [PER_W-1:0] duty_hold [0:5];
  reg [PER_W-1:0] duty_work [0:5];

  // ==================================================
  // Time base
  reg ext_q;
  reg [2:0] pre_cnt;
  reg [2:0] pre_lim;
  reg [2:0] rl_lim;
  reg [2:0] rcnt;
  reg [PER_W-1:0] mcnt;
  // External count input is taken as synchronous; rising edge is one tick
  wire in_tick = ext_sel ? (external_count_clock_input & ~ext_q) : 1'b1;
  wire pwm_tick = en & in_tick & (pre_cnt >= pre_lim);
  wire [PER_W-1:0] per_last = (per_work == {PER_W{1'b0}}) ? {PER_W{1'b0}} :
                              per_work - {{(PER_W-1){1'b0}}, 1'b1};
  wire per_end = pwm_tick & (mcnt >= per_last);
  wire reload = per_end & (rcnt >= rl_lim);
  wire [8:0] db_len = (db == 8'h00) ? `PCDFM_DB_MAX : {1'b0, db}; // RULE9
  wire [9:0] minw = {1'b0, db_len} + {2'b00, mpf}; // RULE12

  always @* begin
    case (pre_work) // RULE5 RULE7
      2'b00: pre_lim = 3'h0;
      2'b01: pre_lim = 3'h1;
      2'b10: pre_lim = 3'h3;
      default: pre_lim = 3'h7;
    endcase
    case (rl_work) // RULE2 RULE7
      2'b00: rl_lim = 3'h0;
      2'b01: rl_lim = 3'h1;
      2'b10: rl_lim = 3'h3;
      default: rl_lim = 3'h7;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= 1'b0;
      pre_cnt <= 3'h0;
      mcnt <= {PER_W{1'b0}};
      rcnt <= 3'h0;
    end else begin
      ext_q <= external_count_clock_input;
      if (!en) begin
        pre_cnt <= 3'h0;
        mcnt <= {PER_W{1'b0}};
        rcnt <= 3'h0;
      end else begin
        if (in_tick)
          pre_cnt <= (pre_cnt >= pre_lim) ? 3'h0 : pre_cnt + 3'h1;
        if (per_end) begin
          mcnt <= {PER_W{1'b0}};
          rcnt <= reload ? 3'h0 : rcnt + 3'h1; // RULE2
        end else if (pwm_tick) begin
          mcnt <= mcnt + {{(PER_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ==================================================
  // Faults
  reg dbg_q;
  wire dbg_entry = debug_mode & ~dbg_q;
  wire hit_dbg = dbg_entry & ~fm[`PCDFM_FM_DBG]; // RULE13
  wire hit_f1 = fault_one_in & ~fm[`PCDFM_FM_F1]; // RULE14
  wire hit_c0 = comparator_in & ~fm[`PCDFM_FM_C0]; // RULE14
  wire hit_f0 = fault_zero_pin & ~fm[`PCDFM_FM_F0]; // RULE14
  wire any_hit = hit_dbg | hit_f1 | hit_c0 | hit_f0;
  wire lvl_dbg = debug_mode & ~fm[`PCDFM_FM_DBG];
  wire any_lvl = lvl_dbg | hit_f1 | hit_c0 | hit_f0;
  wire [7:0] st_set = {reload, 1'b0, hit_dbg, 2'b00, hit_f1, hit_c0, hit_f0}; // RULE19
  // Fault flags only clear once their source has gone away
  wire [7:0] src_lvl = {2'b00, debug_mode, 2'b00, fault_one_in, comparator_in, fault_zero_pin};
  wire [7:0] st_clr = (wr && idx == `PCDFM_IDX_CLR) ? (wd & ~src_lvl) : 8'h00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_q <= 1'b0;
      fault_active <= 1'b0;
      st <= 8'h00;
      irq <= 1'b0;
    end else begin
      dbg_q <= debug_mode;
      // Automatic recovery only: a new period with all unmasked sources quiet
      if (any_hit)
        fault_active <= 1'b1; // RULE16
      else if (per_end && !any_lvl)
        fault_active <= 1'b0; // RULE16
      st <= ((st & ~st_clr) | st_set) & `PCDFM_ST_MASK;
      irq <= |(st & ien);
    end
  end

  // ==================================================
  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ext_sel, ready, en} <= `PCDFM_CTRL0_RST;
      {rl_hold, ind, pol, pre_hold} <= `PCDFM_CTRL1_RST;
      rl_work <= 2'b00;
      pre_work <= 2'b00;
      db <= `PCDFM_DB_RST;
      db_lock <= 1'b0;
      mpf <= `PCDFM_MPF_RST;
      fm <= `PCDFM_FM_RST;
      fm_lock <= 1'b0;
      ien <= 8'h00;
      per_hold <= `PCDFM_PER_RST;
      per_work <= `PCDFM_PER_RST;
    end else begin
      if (per_end)
        rl_work <= rl_hold; // RULE1
      if (reload && ready) begin
        pre_work <= pre_hold; // RULE6 RULE18
        per_work <= per_hold; // RULE18
        ready <= 1'b0;
      end
      if (wr) begin
        case (idx)
          `PCDFM_IDX_CTRL0: begin
            en <= wd[`PCDFM_C0_EN];
            ready <= wd[`PCDFM_C0_READY];
            ext_sel <= wd[`PCDFM_C0_EXTSEL];
          end
          `PCDFM_IDX_CTRL1: begin
            rl_hold <= wd[`PCDFM_C1_RL_HI:`PCDFM_C1_RL_LO]; // RULE1
            ind <= wd[`PCDFM_C1_IND]; // RULE3
            pol <= wd[`PCDFM_C1_POL_HI:`PCDFM_C1_POL_LO]; // RULE4
            pre_hold <= wd[`PCDFM_C1_PRE_HI:`PCDFM_C1_PRE_LO]; // RULE6
          end
          `PCDFM_IDX_DB: begin
            if (!db_lock) begin
              db <= wd; // RULE10
              db_lock <= 1'b1; // RULE10
            end
          end
          `PCDFM_IDX_MPF: mpf <= wd;
          `PCDFM_IDX_FAULT_ZERO_PIN_MASK: begin
            if (!fm_lock) begin
              fm <= fm | (wd & `PCDFM_FM_WMASK); // RULE15
              fm_lock <= 1'b1; // RULE15
            end
          end
          `PCDFM_IDX_IEN: ien <= wd & `PCDFM_ST_MASK;
          `PCDFM_IDX_PER: per_hold <= pwdata[PER_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ==================================================
  // Channels: duty, min pulse filter
  wire [5:0] raw;
  wire [5:0] cand;
  wire [5:0] filt_out;
  wire [2:0] dead;

  genvar c;
  generate
    for (c = 0; c < 6; c = c + 1) begin : g_ch
      reg filt;
      reg [9:0] fcnt;
      assign raw[c] = en & (mcnt < duty_work[c]);
      assign filt_out[c] = filt;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          duty_hold[c] <= `PCDFM_DUTY_RST;
          duty_work[c] <= `PCDFM_DUTY_RST;
          filt <= 1'b0;
          fcnt <= 10'h000;
        end else begin
          if (wr && idx == `PCDFM_IDX_DUTY0 + c)
            duty_hold[c] <= pwdata[PER_W-1:0];
          if (reload && ready)
            duty_work[c] <= duty_hold[c]; // RULE18
          // A level must persist minw PWM clocks before it reaches the pin
          if (!en) begin
            filt <= 1'b0;
            fcnt <= 10'h000;
          end else if (cand[c] == filt) begin
            fcnt <= 10'h000;
          end else if (fcnt >= minw) begin
            filt <= cand[c]; // RULE12
            fcnt <= 10'h000;
          end else if (pwm_tick) begin
            fcnt <= fcnt + 10'h001; // RULE12
          end
        end
      end
    end
  endgenerate

  // ==================================================
  // Pairs: deadband, polarity, fault off-state
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pair
      reg prev_h;
      reg [8:0] dbc;
      assign dead[p] = (dbc != 9'h000);
      assign cand[2*p] = ind ? raw[2*p] : (raw[2*p] & ~dead[p]); // RULE3 RULE11
      assign cand[2*p+1] = ind ? raw[2*p+1] :
                           (~raw[2*p] & en & ~dead[p]); // RULE3 RULE11
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_h <= 1'b0;
          dbc <= 9'h000;
          pwm_high[p] <= 1'b0;
          pwm_low[p] <= 1'b0;
        end else begin
          prev_h <= raw[2*p];
          // Deadband uses the undivided input clock, not the prescaler
          if (!ind && raw[2*p] != prev_h)
            dbc <= db_len; // RULE8
          else if (in_tick && dead[p])
            dbc <= dbc - 9'h001; // RULE8
          if (fault_active) begin
            pwm_high[p] <= pol[p]; // RULE16
            pwm_low[p] <= pol[p]; // RULE16
          end else begin
            pwm_high[p] <= filt_out[2*p] ^ pol[p]; // RULE4
            pwm_low[p] <= filt_out[2*p+1] ^ pol[p]; // RULE4
          end
        end
      end
    end
  endgenerate

  // ==================================================
  // Read path and handshake
  reg [31:0] next_rdata;
  reg next_err;
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (idx >= `PCDFM_IDX_DUTY0 && idx <= `PCDFM_IDX_DUTY5) begin
      next_rdata[PER_W-1:0] = duty_hold[idx[2:0] - 3'h0];
    end else begin
      case (idx)
        `PCDFM_IDX_CTRL0: next_rdata[2:0] = {ext_sel, ready, en};
        `PCDFM_IDX_CTRL1: next_rdata[7:0] = {rl_hold, ind, pol, pre_hold}; // RULE1 RULE6
        `PCDFM_IDX_DB: next_rdata[7:0] = db;
        `PCDFM_IDX_MPF: next_rdata[7:0] = mpf;
        `PCDFM_IDX_FAULT_ZERO_PIN_MASK: next_rdata[7:0] = fm;
        `PCDFM_IDX_STAT: next_rdata[7:0] = st;
        `PCDFM_IDX_CLR: next_rdata = 32'h0000_0000;
        `PCDFM_IDX_IEN: next_rdata[7:0] = ien;
        `PCDFM_IDX_PER: next_rdata[PER_W-1:0] = per_hold;
        default: next_err = 1'b1;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      // No wait state: pready is registered from the setup phase, and every bus output comes from a flip-flop
      pready <= psel & ~penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // pcdfm_top

/* File: rtl/pcdfm_map.vh */
`ifndef PCDFM_MAP_VH
`define PCDFM_MAP_VH
// ==================================================
// Register indexes (byte address = 4 * index)
`define PCDFM_IDX_CTRL0 24'hFFE380
`define PCDFM_IDX_CTRL1 24'hFFE381
`define PCDFM_IDX_DB 24'hFFE382
`define PCDFM_IDX_MPF 24'hFFE383
`define PCDFM_IDX_FAULT_ZERO_PIN_MASK 24'hFFE384
`define PCDFM_IDX_STAT 24'hFFE3A0
`define PCDFM_IDX_CLR 24'hFFE3A1
`define PCDFM_IDX_IEN 24'hFFE3A2
`define PCDFM_IDX_PER 24'hFFE3A3
`define PCDFM_IDX_DUTY0 24'hFFE3A8
`define PCDFM_IDX_DUTY5 24'hFFE3AD
// ==================================================
// Field positions
`define PCDFM_C0_EN 0
`define PCDFM_C0_READY 1
`define PCDFM_C0_EXTSEL 2
`define PCDFM_C1_RL_HI 7
`define PCDFM_C1_RL_LO 6
`define PCDFM_C1_IND 5
`define PCDFM_C1_POL_HI 4
`define PCDFM_C1_POL_LO 2
`define PCDFM_C1_PRE_HI 1
`define PCDFM_C1_PRE_LO 0
`define PCDFM_FM_DBG 5
`define PCDFM_FM_F1 2
`define PCDFM_FM_C0 1
`define PCDFM_FM_F0 0
`define PCDFM_ST_RLD 7
// ==================================================
// Reset values and masks
`define PCDFM_CTRL0_RST 3'h0
`define PCDFM_CTRL1_RST 8'h00
`define PCDFM_DB_RST 8'h01
`define PCDFM_MPF_RST 8'h00
`define PCDFM_FM_RST 8'h00
`define PCDFM_FM_WMASK 8'h27
`define PCDFM_ST_MASK 8'hA7
`define PCDFM_PER_RST 12'hFFF
`define PCDFM_DUTY_RST 12'h000
`define PCDFM_DB_MAX 9'h100
`endif

/* File: tb/pcdfm_stage.sv */
`timescale 1ns/1ps
// ==========
// Power stage with a lagging over-current sense
module pcdfm_stage #(
  parameter LAG = 3
) (
  input wire pclk,
  input wire [2:0] pwm_high,
  input wire [2:0] pwm_low,
  input wire trip_req,
  output reg over_current
);
  integer n = 0;
  integer shoots = 0;
  // Sense filter is slow, so the trip lands LAG+1 cycles late
  always @(posedge pclk) begin
    n <= trip_req ? n + 1 : 0;
    over_current <= trip_req && n >= LAG;
    if (|(pwm_high & pwm_low)) begin
      shoots <= shoots + 1;
    end
  end
endmodule // pcdfm_stage

/* File: tb/pcdfm_sva.sv */
`timescale 1ns/1ps
`include "pcdfm_map.vh"
// ==========
// Port checker
module pcdfm_sva #(
  parameter PER_W = 12,
  parameter ADDR_W = 26
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire comparator_in,
  input wire debug_mode,
  input wire [2:0] pwm_high,
  input wire [2:0] pwm_low,
  input wire fault_active
);
  wire rd = psel && penable && pready && !pwrite;
  wire wr = psel && penable && pready && pwrite && !pslverr;
  wire [23:0] idx = paddr[ADDR_W-1:2];
  reg [7:0] ctl1;
  reg [7:0] db;
  reg [7:0] fm;
  reg db_done;
  reg fm_done;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1 <= 8'h00;
      db <= 8'h01;
      fm <= 8'h00;
      db_done <= 1'b0;
      fm_done <= 1'b0;
    end else if (wr) begin
      if (idx == `PCDFM_IDX_CTRL1) begin
        ctl1 <= pwdata[7:0];
      end
      if (idx == `PCDFM_IDX_DB && !db_done) begin
        db <= pwdata[7:0];
        db_done <= 1'b1;
      end
      if (idx == `PCDFM_IDX_FAULT_ZERO_PIN_MASK && !fm_done) begin
        fm <= pwdata[7:0] & 8'h27;
        fm_done <= 1'b1;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ctl1_holding: assert property (rd && idx == `PCDFM_IDX_CTRL1 |->
    prdata[7:0] == ctl1) else $error("control one readback wrong");
  a_db_first_only: assert property (rd && idx == `PCDFM_IDX_DB |->
    prdata[7:0] == db) else $error("deadband not first write");
  a_mask_once: assert property (rd && idx == `PCDFM_IDX_FAULT_ZERO_PIN_MASK |->
    prdata[7:0] == fm) else $error("fault mask readback wrong");
  a_pair_no_overlap: assert property (!ctl1[5] && ctl1[4:2] == 3'h0 |->
    (pwm_high & pwm_low) == 3'h0) else $error("pair outputs overlap");
  a_cmp_fault: assert property ($rose(comparator_in) && !fm[1] |->
    ##[1:3] fault_active) else $error("comparator fault missed");
  a_dbg_fault: assert property ($rose(debug_mode) && !fm[5] |->
    ##[1:3] fault_active) else $error("debug entry fault missed");
  a_fault_off: assert property (fault_active && $past(fault_active) && ctl1[4:2] == 3'h0
    |-> pwm_high == 3'h0 && pwm_low == 3'h0) else $error("outputs not off in fault");
  a_masked_flag: assert property (rd && idx == `PCDFM_IDX_STAT && fm[0] |->
    !prdata[0]) else $error("masked source flagged");
  cover property (rd && pslverr);
  cover property ($rose(fault_active));
  cover property (wr && idx == `PCDFM_IDX_DB && db_done);
endmodule // pcdfm_sva
bind pcdfm_top pcdfm_sva #(.PER_W(PER_W), .ADDR_W(ADDR_W)) u_pcdfm_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .comparator_in(comparator_in), .debug_mode(debug_mode), .pwm_high(pwm_high),
  .pwm_low(pwm_low), .fault_active(fault_active));

/* File: tb/test_pcdfm_top.sv */
`timescale 1ns/1ps
`include "pcdfm_map.vh"
module test_pcdfm_top;
  reg pclk, presetn, psel, penable, pwrite, fault_zero_pin, debug_mode, trip_req, e;
  reg fault_one_in;
  reg [25:0] paddr;
  reg [31:0] pwdata, q;
  wire [31:0] prdata;
  wire pready, pslverr, comparator_in, fault_active, irq;
  wire [2:0] pwm_high, pwm_low;
  integer n_fail = 0, checked = 0, cyc = 0;
  pcdfm_top u_pcdfm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_clock_input(1'b0), .fault_zero_pin(fault_zero_pin),
    .comparator_in(comparator_in), .fault_one_in(fault_one_in), .debug_mode(debug_mode),
    .pwm_high(pwm_high), .pwm_low(pwm_low), .fault_active(fault_active), .irq(irq));
  pcdfm_stage #(.LAG(3)) u_pcdfm_stage (.pclk(pclk), .pwm_high(pwm_high), .pwm_low(pwm_low),
    .trip_req(trip_req), .over_current(comparator_in));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task wrap_up;
    begin
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task apb(input [23:0] idx, input w, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n >= 20) begin
        n_fail = n_fail + 1;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [23:0] idx, input [7:0] m, input [7:0] exp);
    begin
      apb(idx, 1'b0, 32'h0);
      chk($sformatf("reg %h", idx), {24'h0, exp}, {24'h0, q[7:0] & m});
    end
  endtask
  task wait_fa(input v);
    integer n;
    begin
      n = 0;
      // First period runs on the reset period value, so recovery can take ~4100 cycles
      while (fault_active !== v && n < 6000) begin
        @(posedge pclk);
        n = n + 1;
      end
      chk("fault_active", {31'h0, v}, {31'h0, fault_active});
    end
  endtask
  // Cuts a hang short
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, fault_zero_pin, debug_mode, trip_req} = 7'h00;
    paddr = 26'h0;
    fault_one_in = 1'b0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`PCDFM_IDX_CTRL1, 8'hFF, 8'h00);
    rd(`PCDFM_IDX_DB, 8'hFF, 8'h01);
    rd(`PCDFM_IDX_MPF, 8'hFF, 8'h00);
    rd(`PCDFM_IDX_FAULT_ZERO_PIN_MASK, 8'hFF, 8'h00);
    apb(`PCDFM_IDX_CTRL1, 1'b1, 32'hC3);
    rd(`PCDFM_IDX_CTRL1, 8'hFF, 8'hC3);
    apb(`PCDFM_IDX_DB, 1'b1, 32'h05);
    apb(`PCDFM_IDX_DB, 1'b1, 32'h09);
    rd(`PCDFM_IDX_DB, 8'hFF, 8'h05);
    apb(`PCDFM_IDX_MPF, 1'b1, 32'h02);
    apb(`PCDFM_IDX_PER, 1'b1, 32'h8);
    apb(`PCDFM_IDX_DUTY0, 1'b1, 32'h4);
    apb(`PCDFM_IDX_IEN, 1'b1, 32'h07);
    apb(`PCDFM_IDX_FAULT_ZERO_PIN_MASK, 1'b1, 32'h01);
    apb(`PCDFM_IDX_FAULT_ZERO_PIN_MASK, 1'b1, 32'h06);
    rd(`PCDFM_IDX_FAULT_ZERO_PIN_MASK, 8'hFF, 8'h01);
    apb(`PCDFM_IDX_CTRL0, 1'b1, 32'h3);
    fault_zero_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("masked fault", 32'h0, {31'h0, fault_active});
    fault_zero_pin <= 1'b0;
    rd(`PCDFM_IDX_STAT, 8'h01, 8'h00);
    trip_req <= 1'b1;
    wait_fa(1'b1);
    rd(`PCDFM_IDX_STAT, 8'h02, 8'h02);
    chk("irq", 32'h1, {31'h0, irq});
    trip_req <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(`PCDFM_IDX_CLR, 1'b1, 32'hFF);
    rd(`PCDFM_IDX_STAT, 8'h07, 8'h00);
    wait_fa(1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    rd(`PCDFM_IDX_STAT, 8'h80, 8'h80);
    chk("pwm", 32'h07, {26'h0, pwm_high, pwm_low});
    apb(`PCDFM_IDX_CTRL1, 1'b1, 32'hDF);
    @(posedge pclk);
    chk("pwm inverted", 32'h38, {26'h0, pwm_high, pwm_low});
    apb(`PCDFM_IDX_CTRL1, 1'b1, 32'hE3);
    repeat (100) @(posedge pclk);
    chk("pwm independent", 32'h00, {26'h0, pwm_high, pwm_low});
    apb(`PCDFM_IDX_CTRL1, 1'b1, 32'hC3);
    debug_mode <= 1'b1;
    wait_fa(1'b1);
    fault_one_in <= 1'b1;
    debug_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    fault_one_in <= 1'b0;
    rd(`PCDFM_IDX_STAT, 8'h24, 8'h24);
    apb(24'h000010, 1'b0, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("shoots", 32'h0, u_pcdfm_stage.shoots);
    wrap_up;
  end
endmodule // test_pcdfm_top
